// [ext_temp_cal_pkg.sv]
`default_nettype none

package ext_temp_cal_pkg;

   // -------------------------------------------------------------------------
   // Command codes
   // -------------------------------------------------------------------------
   localparam logic [7:0] CMD_EXT_TEMP_GAIN    = 8'hd9;
   localparam logic [7:0] CMD_EXT_TEMP_BIAS    = 8'hda;
   localparam logic [7:0] CMD_ALERT_FAULT_MASK = 8'hdb;

   // -------------------------------------------------------------------------
   // Widths and reset values
   // -------------------------------------------------------------------------
   localparam int          CAL_W            = 16;
   localparam int          MASK_W           = 56;
   localparam int          MASK_BYTES       = 7;
   localparam logic [15:0] GAIN_RESET       = 16'hba00;
   localparam logic [15:0] BIAS_RESET       = 16'h0000;
   localparam logic [55:0] MASK_RESET       = 56'h00_0000_0000_0000;
   localparam int          MASK_UNUSED_BYTE = 5;

   // -------------------------------------------------------------------------
   // Linear-11 field layout
   // -------------------------------------------------------------------------
   localparam int EXP_MSB  = 15;
   localparam int EXP_LSB  = 11;
   localparam int MANT_MSB = 10;
   localparam int MANT_LSB = 0;

   // -------------------------------------------------------------------------
   // Fixed-point arithmetic
   // -------------------------------------------------------------------------
   localparam int TEMP_W     = 16;
   localparam int TEMP_FRAC  = 4;
   localparam int GUARD_FRAC = 16;
   localparam int WORK_W     = 48;
   localparam int REM_W      = 12;
   localparam int DIV_STEPS  = 48;
   localparam int CNT_W      = 6;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIV  = 3'b010,
      ST_FIN  = 3'b100
   } conv_state_type;

endpackage : ext_temp_cal_pkg

`default_nettype wire

// [ext_temp_cal_alert_mask_regs.sv]
`default_nettype none

// Functional notes
// - Paged two-byte Linear-11 gain register, writable, reset to unity encoding ba00.
// - Second temperature equals raw external temperature divided by gain, plus offset.
// - Writable external temperature offset in degrees Celsius, reset to zero.
// - Offset stored per page, two bytes, readable and writable.
// - Seven-byte alert mask, writable except byte 5, which always reads zero; masked faults never assert the alert pin.
// - Each mask bit masks the status fault at the same bit position.
// - Byte 6 vendor, 4 comms/memory/logic, 3 temp, 2 input, 1 current, 0 voltage.
// - All alert mask bits clear after reset.
module ext_temp_cal_alert_mask_regs #(
   parameter int PAGES = 2
) (
   input  wire  logic                     ref_clk,
   input  wire  logic                     rst_n,
   input  wire  logic                     cmd_valid,
   input  wire  logic                     cmd_write,
   input  wire  logic [7:0]               cmd_code,
   input  wire  logic [$clog2(PAGES)-1:0] cmd_page,
   input  wire  logic [55:0]              cmd_wdata,
   output logic       [55:0]              rd_data_q,
   output logic                           rd_valid_q,
   output logic                           cmd_err_q,
   input  wire  logic                     temp_sample_valid,
   input  wire  logic [$clog2(PAGES)-1:0] temp_sample_page,
   input  wire  logic [15:0]              ext_temp_input,
   output logic                           temp_busy_q,
   output logic       [15:0]              temp2_q,
   output logic       [$clog2(PAGES)-1:0] temp2_page_q,
   output logic                           temp2_valid_q,
   input  wire  logic [55:0]              fault_status,
   output logic                           alert_pin_out_o,
   output logic                           alert_pin_out_oe
);

   localparam int PAGE_W = $clog2(PAGES);

   if (PAGES < 2 || PAGES > 32) begin : g_bad_pages
      $error("PAGES must lie between 2 and 32.");
   end

   typedef struct packed {
      ext_temp_cal_pkg::conv_state_type     state;
      logic [PAGES-1:0][15:0]               gain;
      logic [PAGES-1:0][15:0]               bias;
      logic [55:0]                          mask;
      logic [55:0]                          rd_data;
      logic                                 rd_valid;
      logic                                 cmd_err;
      logic [ext_temp_cal_pkg::CNT_W-1:0]   cnt;
      logic [ext_temp_cal_pkg::WORK_W-1:0]  quo;
      logic [ext_temp_cal_pkg::REM_W-1:0]   rem;
      logic [10:0]                          den;
      logic                                 neg;
      logic [PAGE_W-1:0]                    page;
      logic [15:0]                          temp2;
      logic [PAGE_W-1:0]                    temp2_page;
      logic                                 temp2_valid;
      logic                                 alert_oe;
      logic                                 busy;
      logic                                 alert_val;
   } regs_type;

   regs_type st_q;
   regs_type st_d;

   // -------------------------------------------------------------------------
   // Linear-11 scaling
   // -------------------------------------------------------------------------
   // Scales a fixed-point value by two to the signed exponent.
   function automatic logic signed [47:0] scale_exp(input logic signed [47:0] v,
                                                   input logic [4:0]          e);
      logic [5:0] n;
      n = 6'h00 - {e[4], e};
      if (e[4]) begin
         scale_exp = v >>> n;
      end else begin
         scale_exp = v <<< e;
      end
   endfunction : scale_exp

   // Tells whether a page index names one of the implemented pages.
   function automatic logic page_ok(input logic [PAGE_W-1:0] p);
      page_ok = 32'(p) < PAGES;
   endfunction : page_ok

   logic               [10:0] gain_mant;
   logic               [4:0]  gain_exp;
   logic               [15:0] temp_abs;
   logic               [10:0] mant_abs;
   logic signed        [47:0] num_scaled;
   logic               [15:0] bias_word;
   logic signed        [47:0] bias_scaled;
   logic               [11:0] rem_shift;
   logic signed        [49:0] quo_signed;
   logic signed        [49:0] sum;
   logic signed        [33:0] sum_q4;
   logic               [55:0] alert_src;

   always_comb begin
      gain_mant  = st_q.gain[temp_sample_page][ext_temp_cal_pkg::MANT_MSB:
                                               ext_temp_cal_pkg::MANT_LSB];
      gain_exp   = st_q.gain[temp_sample_page][ext_temp_cal_pkg::EXP_MSB:
                                               ext_temp_cal_pkg::EXP_LSB];
      temp_abs   = ext_temp_input[15] ? 16'h0000 - ext_temp_input : ext_temp_input;
      mant_abs   = gain_mant[10] ? 11'h000 - gain_mant : gain_mant;
      // Dividing by m*2^e is dividing by m after scaling by 2^-e.
      num_scaled = scale_exp({16'h0000, temp_abs, 16'h0000}, 5'h00 - gain_exp);
      bias_word  = st_q.bias[st_q.page];
      bias_scaled = scale_exp({{17{bias_word[10]}}, bias_word[10:0], 20'h00000},
                              bias_word[15:11]);
      rem_shift  = {st_q.rem[10:0], st_q.quo[47]};
      quo_signed = st_q.neg ? 50'sd0 - $signed({2'b00, st_q.quo})
                            : $signed({2'b00, st_q.quo});
      sum        = quo_signed + {{2{bias_scaled[47]}}, bias_scaled};
      sum_q4     = sum[49:16];
   end

   // -------------------------------------------------------------------------
   // Alert gating
   // -------------------------------------------------------------------------
   for (genvar b = 0; b < ext_temp_cal_pkg::MASK_BYTES; b++) begin : g_alert
      assign alert_src[b*8 +: 8] = fault_status[b*8 +: 8] & ~st_q.mask[b*8 +: 8];
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      st_d             = st_q;
      st_d.rd_valid    = 1'b0;
      st_d.cmd_err     = 1'b0;
      st_d.temp2_valid = 1'b0;
      st_d.alert_oe    = |alert_src;
      // The pin is open drain: its value stays low and the enable carries the alert.
      st_d.alert_val   = 1'b0;

      if (cmd_valid) begin
         st_d.rd_data = 56'h00_0000_0000_0000;
         case (cmd_code)
            ext_temp_cal_pkg::CMD_EXT_TEMP_GAIN: begin
               if (!page_ok(cmd_page)) begin
                  st_d.cmd_err = 1'b1;
               end else if (cmd_write) begin
                  st_d.gain[cmd_page] = cmd_wdata[15:0];
               end else begin
                  st_d.rd_data  = {40'h00_0000_0000, st_q.gain[cmd_page]};
                  st_d.rd_valid = 1'b1;
               end
            end
            ext_temp_cal_pkg::CMD_EXT_TEMP_BIAS: begin
               if (!page_ok(cmd_page)) begin
                  st_d.cmd_err = 1'b1;
               end else if (cmd_write) begin
                  st_d.bias[cmd_page] = cmd_wdata[15:0];
               end else begin
                  st_d.rd_data  = {40'h00_0000_0000, st_q.bias[cmd_page]};
                  st_d.rd_valid = 1'b1;
               end
            end
            ext_temp_cal_pkg::CMD_ALERT_FAULT_MASK: begin
               if (cmd_write) begin
                  st_d.mask = cmd_wdata;
                  // The unused status byte has no mask behind it.
                  st_d.mask[ext_temp_cal_pkg::MASK_UNUSED_BYTE*8 +: 8] = 8'h00;
               end else begin
                  st_d.rd_data  = st_q.mask;
                  st_d.rd_valid = 1'b1;
               end
            end
            default: begin
               st_d.cmd_err = 1'b1;
            end
         endcase
      end

      case (st_q.state)
         ext_temp_cal_pkg::ST_IDLE: begin
            if (temp_sample_valid && page_ok(temp_sample_page)) begin
               st_d.quo   = num_scaled;
               st_d.rem   = 12'h000;
               st_d.den   = mant_abs;
               st_d.neg   = ext_temp_input[15] ^ gain_mant[10];
               st_d.page  = temp_sample_page;
               st_d.cnt   = 6'h00;
               st_d.state = ext_temp_cal_pkg::ST_DIV;
            end
         end
         ext_temp_cal_pkg::ST_DIV: begin
            // Restoring division, one quotient bit per cycle.
            if (rem_shift >= {1'b0, st_q.den}) begin
               st_d.rem = rem_shift - {1'b0, st_q.den};
               st_d.quo = {st_q.quo[46:0], 1'b1};
            end else begin
               st_d.rem = rem_shift;
               st_d.quo = {st_q.quo[46:0], 1'b0};
            end
            st_d.cnt = st_q.cnt + 6'h01;
            if (st_q.cnt == 6'(ext_temp_cal_pkg::DIV_STEPS - 1)) begin
               st_d.state = ext_temp_cal_pkg::ST_FIN;
            end
         end
         ext_temp_cal_pkg::ST_FIN: begin
            // Saturate the Q.4 result to 16 bits.
            if (sum_q4 > 34'sd32767) begin
               st_d.temp2 = 16'h7fff;
            end else if (sum_q4 < -34'sd32768) begin
               st_d.temp2 = 16'h8000;
            end else begin
               st_d.temp2 = sum_q4[15:0];
            end
            st_d.temp2_page  = st_q.page;
            st_d.temp2_valid = 1'b1;
            st_d.state       = ext_temp_cal_pkg::ST_IDLE;
         end
         default: begin
            st_d.state = ext_temp_cal_pkg::ST_IDLE;
         end
      endcase
      st_d.busy = (st_d.state != ext_temp_cal_pkg::ST_IDLE);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q             <= '0;
         st_q.state       <= ext_temp_cal_pkg::ST_IDLE;
         st_q.gain        <= {PAGES{ext_temp_cal_pkg::GAIN_RESET}};
         st_q.bias        <= {PAGES{ext_temp_cal_pkg::BIAS_RESET}};
         st_q.mask        <= ext_temp_cal_pkg::MASK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data_q        = st_q.rd_data;
   assign rd_valid_q       = st_q.rd_valid;
   assign cmd_err_q        = st_q.cmd_err;
   assign temp_busy_q      = st_q.busy;
   assign temp2_q          = st_q.temp2;
   assign temp2_page_q     = st_q.temp2_page;
   assign temp2_valid_q    = st_q.temp2_valid;
   assign alert_pin_out_o  = st_q.alert_val;
   assign alert_pin_out_oe = st_q.alert_oe;

endmodule : ext_temp_cal_alert_mask_regs

`default_nettype wire

// [ext_temp_cal_alert_mask_regs_assertions.sv]
`default_nettype none
// -------------------------------------------------------------------
// Port checker
// -------------------------------------------------------------------
module ext_temp_cal_checks #(
   parameter int PAGES = 2
) (
   input wire logic                     ref_clk,
   input wire logic                     rst_n,
   input wire logic                     cmd_valid,
   input wire logic                     cmd_write,
   input wire logic [7:0]               cmd_code,
   input wire logic [$clog2(PAGES)-1:0] cmd_page,
   input wire logic [55:0]              cmd_wdata,
   input wire logic [55:0]              rd_data_q,
   input wire logic                     rd_valid_q,
   input wire logic                     cmd_err_q,
   input wire logic                     temp_sample_valid,
   input wire logic [$clog2(PAGES)-1:0] temp_sample_page,
   input wire logic                     temp_busy_q,
   input wire logic [$clog2(PAGES)-1:0] temp2_page_q,
   input wire logic                     temp2_valid_q,
   input wire logic [55:0]              fault_status,
   input wire logic                     alert_pin_out_o,
   input wire logic                     alert_pin_out_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic        known;
   logic        take;
   logic        is_mask;
   logic [55:0] mask_model;
   assign is_mask = cmd_code == ext_temp_cal_pkg::CMD_ALERT_FAULT_MASK;
   assign known   = cmd_code inside {ext_temp_cal_pkg::CMD_EXT_TEMP_GAIN,
                                     ext_temp_cal_pkg::CMD_EXT_TEMP_BIAS,
                                     ext_temp_cal_pkg::CMD_ALERT_FAULT_MASK} && cmd_page < PAGES;
   assign take    = temp_sample_valid && !temp_busy_q && temp_sample_page < PAGES;
   // Mask as the host wrote it; the unused status byte never holds a mask bit.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_model <= 56'h00_0000_0000_0000;
      end else if (cmd_valid && cmd_write && is_mask) begin
         mask_model <= cmd_wdata & 56'hff_00ff_ffff_ffff;
      end
   end
   a_read_answer: assert property (cmd_valid && !cmd_write && known |=> rd_valid_q)
      else $error("read not answered");
   a_bad_code: assert property (cmd_valid && !known |=> cmd_err_q && !rd_valid_q)
      else $error("bad command not refused");
   a_write_silent: assert property (cmd_valid && cmd_write |=> !rd_valid_q)
      else $error("write gave read answer");
   a_short_width: assert property (
      rd_valid_q && !$past(is_mask) |-> rd_data_q[55:16] == 40'h00_0000_0000)
      else $error("short read not zero extended");
   a_byte5_zero: assert property (
      rd_valid_q && $past(is_mask) |-> rd_data_q[47:40] == 8'h00)
      else $error("mask byte 5 not zero");
   a_conv_latency: assert property (
      take |=> (temp_busy_q && !temp2_valid_q)[*8] ##42 (temp2_valid_q && !temp_busy_q))
      else $error("conversion timing wrong");
   a_conv_page: assert property (take |-> ##50 temp2_page_q == $past(temp_sample_page, 50))
      else $error("result page wrong");
   a_pin_low: assert property (alert_pin_out_o == 1'b0)
      else $error("alert pin value not low");
   a_alert_gate: assert property (
      alert_pin_out_oe == $past(|(fault_status & ~mask_model)))
      else $error("alert enable does not follow unmasked faults");
endmodule : ext_temp_cal_checks

bind ext_temp_cal_alert_mask_regs ext_temp_cal_checks #(.PAGES(PAGES)) u_checks (
   .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
   .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q),
   .rd_valid_q(rd_valid_q), .cmd_err_q(cmd_err_q), .temp_sample_valid(temp_sample_valid),
   .temp_sample_page(temp_sample_page), .temp_busy_q(temp_busy_q),
   .temp2_page_q(temp2_page_q), .temp2_valid_q(temp2_valid_q),
   .fault_status(fault_status), .alert_pin_out_o(alert_pin_out_o),
   .alert_pin_out_oe(alert_pin_out_oe));
`default_nettype wire

// [mgmt_host_model.sv]
`default_nettype none
// -------------------------------------------------------------------
// Command host
// -------------------------------------------------------------------
module mgmt_host_model (
   input  wire logic        ref_clk,
   input  wire logic [55:0] rd_data_q,
   input  wire logic        rd_valid_q,
   input  wire logic        cmd_err_q,
   output var  logic        cmd_valid,
   output var  logic        cmd_write,
   output var  logic [7:0]  cmd_code,
   output var  logic [0:0]  cmd_page,
   output var  logic [55:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_page  = 1'b0;
      cmd_wdata = 56'h0;
   end
   // One-cycle command; write data is scrambled once the command is taken.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [0:0] p,
                       input logic [55:0] d, output logic [55:0] rd, output logic [1:0] ans);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code  <= c;
      cmd_page  <= p;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      cmd_wdata <= ~d;
      #1;
      rd  = rd_data_q;
      ans = {cmd_err_q, rd_valid_q};
   endtask : xfer
endmodule : mgmt_host_model
`default_nettype wire

// [ext_temp_cal_alert_mask_regs_test.sv]
`default_nettype none
module ext_temp_cal_alert_mask_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0, rst_n = 1'b0, temp_sample_valid = 1'b0;
   logic        cmd_valid, cmd_write, rd_valid_q, cmd_err_q, temp_busy_q, temp2_valid_q;
   logic        alert_pin_out_o, alert_pin_out_oe;
   logic [7:0]  cmd_code;
   logic [0:0]  cmd_page, temp2_page_q, temp_sample_page = 1'b0;
   logic [15:0] temp2_q, ext_temp_input = 16'h0;
   logic [55:0] cmd_wdata, rd_data_q, rd, fault_status = 56'h0;
   logic [1:0]  ans;
   int          bad_count = 0, cmp_count = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   ext_temp_cal_alert_mask_regs #(.PAGES(2)) u_ext_temp_cal_alert_mask_regs (
      .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .cmd_err_q(cmd_err_q), .temp_sample_valid(temp_sample_valid),
      .temp_sample_page(temp_sample_page), .ext_temp_input(ext_temp_input),
      .temp_busy_q(temp_busy_q), .temp2_q(temp2_q), .temp2_page_q(temp2_page_q),
      .temp2_valid_q(temp2_valid_q), .fault_status(fault_status),
      .alert_pin_out_o(alert_pin_out_o), .alert_pin_out_oe(alert_pin_out_oe));
   mgmt_host_model u_host (
      .ref_clk(ref_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .cmd_err_q(cmd_err_q),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_wdata(cmd_wdata));
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // A second sample while busy must leave the first result alone.
   task automatic conv(input logic [0:0] pg, input logic [15:0] raw, input logic [15:0] exp);
      int n;
      @(posedge ref_clk);
      temp_sample_valid <= 1'b1;
      temp_sample_page  <= pg;
      ext_temp_input    <= raw;
      @(posedge ref_clk);
      temp_sample_valid <= 1'b0;
      repeat (5) @(posedge ref_clk);
      temp_sample_valid <= 1'b1;
      ext_temp_input    <= ~raw;
      @(posedge ref_clk);
      temp_sample_valid <= 1'b0;
      n = 0;
      while (temp2_valid_q !== 1'b1 && n < 60) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(temp2_q, exp);
      chk(temp2_page_q, pg);
   endtask : conv
   task automatic alert(input logic [55:0] st, input logic exp);
      @(posedge ref_clk);
      fault_status <= st;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(alert_pin_out_oe, exp);
   endtask : alert
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         end_of_test;
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         u_host.xfer(1'b0, 8'hd9, p[0], 56'h0, rd, ans);
         chk(rd, 56'hba00);
         chk(ans, 2'b01);
         u_host.xfer(1'b0, 8'hda, p[0], 56'h0, rd, ans);
         chk(rd, 56'h0);
      end
      u_host.xfer(1'b0, 8'hdb, 1'b0, 56'h0, rd, ans);
      chk(rd, 56'h0);
      alert(56'h01 << 16, 1'b1);
      u_host.xfer(1'b1, 8'hd9, 1'b0, 56'h0802, rd, ans);
      u_host.xfer(1'b1, 8'hda, 1'b0, 56'h0003, rd, ans);
      u_host.xfer(1'b1, 8'hda, 1'b1, 56'h07fb, rd, ans);
      u_host.xfer(1'b1, 8'hdc, 1'b0, 56'h1234, rd, ans);
      chk(ans, 2'b10);
      u_host.xfer(1'b0, 8'hd9, 1'b0, 56'h0, rd, ans);
      chk(rd, 56'h0802);
      u_host.xfer(1'b0, 8'hda, 1'b1, 56'h0, rd, ans);
      chk(rd, 56'h07fb);
      conv(1'b0, 16'h0190, 16'h0094);
      conv(1'b1, 16'h0190, 16'h0140);
      for (int b = 0; b < 7; b++) begin
         u_host.xfer(1'b1, 8'hdb, 1'b0, 56'h8 << (8 * b), rd, ans);
         alert(56'h8 << (8 * b), b == 5);
         alert(56'h10 << (8 * b), 1'b1);
      end
      u_host.xfer(1'b1, 8'hdb, 1'b0, 56'hffffffffffffff, rd, ans);
      u_host.xfer(1'b0, 8'hdb, 1'b0, 56'h0, rd, ans);
      chk(rd, 56'hff00ffffffffff);
      alert(56'hff00ffffffffff, 1'b0);
      end_of_test;
   end
endmodule : ext_temp_cal_alert_mask_regs_test
`default_nettype wire
